// ---- hw/cal_link_defs.svh ----
// Timing counts, address fields and reset values shared by both link ends.
// Assumes a 250 MHz system clock and a link clock divided down from it.
`ifndef CAL_LINK_DEFS_SVH
`define CAL_LINK_DEFS_SVH

`define CLK_PERIOD_NS            4
`define CK_DIV                   8
`define CK_HALF                  4
`define CK_PERIOD_NS             (`CLK_PERIOD_NS * `CK_DIV)

`define ADDR_RTT_HI              6
`define ADDR_RTT_LO              2
`define RTT_RESET                2'h0

`define CALIB_OUTPUT_DELAY_NS    12
`define CALIB_OUTPUT_DELAY_CK    (((`CALIB_OUTPUT_DELAY_NS / `CK_PERIOD_NS) < 1) ? 1 : \
                                  (`CALIB_OUTPUT_DELAY_NS / `CK_PERIOD_NS))
`define TERM_ON_DELAY_CK         2
`define TERM_OFF_DELAY_HALF_CK   5
`define TERM_OFF_DELAY_CK        ((`TERM_OFF_DELAY_HALF_CK + 1) / 2)
`define MODE_UPDATE_WINDOW_NS    12
`define MODE_UPDATE_WINDOW_CK    ((`MODE_UPDATE_WINDOW_NS + `CK_PERIOD_NS - 1) / `CK_PERIOD_NS)

`endif

// ---- hw/cal_link_pkg.sv ----
// Types shared by the memory end and the controller end of the link.
// Assumes nothing of its surroundings.
package cal_link_pkg;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_EXT_REG_ONE_WR,
    CMD_DRIVE_HIGH,
    CMD_DRIVE_LOW,
    CMD_ADJUST,
    CMD_CAL_EXIT
  } cmd_e;

  typedef enum logic [2:0] {
    OP_DRIVE_HIGH,
    OP_DRIVE_LOW,
    OP_ADJUST,
    OP_CAL_EXIT,
    OP_SET_RTT,
    OP_TERM_ON,
    OP_TERM_OFF
  } op_e;

  // Write latency in adjust mode is additive plus CAS latency less one.
  function automatic logic [3:0] write_latency(input logic [2:0] al, input logic [2:0] cl);
    write_latency = 4'({1'b0, al} + {1'b0, cl} - 4'h1);
  endfunction : write_latency

endpackage : cal_link_pkg

// ---- hw/cal_link.sv ----
// Link between the memory controller and the memory device.
// Assumes the bench connects one controller end and one memory end.
`timescale 1ns/1ps
interface cal_link;
  import cal_link_pkg::*;

  logic        ck;
  cmd_e        cmd;
  logic [12:0] addr;
  logic        term_ctl;
  logic [7:0]  dq_c;
  logic        dq_c_oe;
  logic [7:0]  dq_d;
  logic        dq_d_oe;
  logic [7:0]  dq;

  // Resolved data bus level; an undriven bus reads as zero.
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : 8'h00);

  modport dram (input ck, input cmd, input addr, input term_ctl, input dq,
                output dq_d, output dq_d_oe);
  modport ctrl (output ck, output cmd, output addr, output term_ctl, output dq_c,
                output dq_c_oe, input dq);
endinterface : cal_link

// ---- hw/dram_cal_end.sv ----
// Memory-device end: driver calibration modes and termination updates.
// Assumes all link inputs come from another domain and the link clock runs slow.
// Functional notes
// - Drive all outputs after calibration output delay.
// - Release drivers after calibration exit delay.
// - Controller uses drive modes to measure impedance.
// - Adjust write latency equals read latency less one.
// - Adjust bits use one fixed order always.
// - Lower termination, wait turn-off before register write.
// - Hold termination low through mode update window.
// - Apply new termination after update window ends.
// - Register one write updates termination from A6,A2.
// - After refresh violation, rewrite data before reading.
// - Termination turns on two link edges later.
`timescale 1ns/1ps
`include "cal_link_defs.svh"
module dram_cal_end
  import cal_link_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  cal_link.dram           link,
  input  wire logic [2:0] additive_latency,
  input  wire logic [2:0] cas_latency,
  output logic            term_on,
  output logic [1:0]      rtt_setting,
  output logic [3:0]      adjust_pattern,
  output logic            adjust_valid,
  output logic            drive_active
);

  typedef enum logic [1:0] {DRV_OFF, DRV_ENTER, DRV_ON, DRV_EXIT} drv_e;
  typedef enum logic [1:0] {ADJ_IDLE, ADJ_WAIT, ADJ_DATA} adj_e;

  logic        ck_s1, ck_s2, ck_s3;
  cmd_e        cmd_s1, cmd_s2;
  logic [12:0] addr_s1, addr_s2;
  logic        term_s1, term_s2;
  logic [7:0]  dq_s1, dq_s2;
  logic        ck_rise;

  logic [2:0]  hist, next_hist;
  logic        next_term_on;
  logic [1:0]  rtt_pend, next_rtt_pend;
  logic [1:0]  next_rtt_setting;
  logic [3:0]  mod_cnt, next_mod_cnt;
  logic        mod_busy, next_mod_busy;

  drv_e        drv, next_drv;
  logic [3:0]  oit_cnt, next_oit_cnt;
  logic        level, next_level;
  logic        next_drive_active;
  logic [7:0]  dq_out, next_dq_out;
  logic        dq_oe, next_dq_oe;

  adj_e        adj, next_adj;
  logic [3:0]  adj_cnt, next_adj_cnt;
  logic [1:0]  beat, next_beat;
  logic [3:0]  next_adjust_pattern;
  logic        next_adjust_valid;

  // Two-flop synchronisers; a third ck flop finds the rising edge.
  always_ff @(posedge clk) begin
    ck_s1   <= link.ck;
    ck_s2   <= ck_s1;
    ck_s3   <= ck_s2;
    cmd_s1  <= link.cmd;
    cmd_s2  <= cmd_s1;
    addr_s1 <= link.addr;
    addr_s2 <= addr_s1;
    term_s1 <= link.term_ctl;
    term_s2 <= term_s1;
    dq_s1   <= link.dq;
    dq_s2   <= dq_s1;
  end

  assign ck_rise = ck_s2 & ~ck_s3;

  // Termination control history, on and off timing, and register updates.
  always_comb begin
    next_hist        = hist;
    next_term_on     = term_on;
    next_rtt_pend    = rtt_pend;
    next_rtt_setting = rtt_setting;
    next_mod_cnt     = mod_cnt;
    next_mod_busy    = mod_busy;
    if (ck_rise) begin
      next_hist = {hist[1:0], term_s2};
      if (hist[`TERM_ON_DELAY_CK - 1]) begin
        next_term_on = 1'b1;
      end else if (!hist[`TERM_OFF_DELAY_CK - 1]) begin
        next_term_on = 1'b0;
      end
      if (cmd_s2 == CMD_EXT_REG_ONE_WR) begin
        next_rtt_pend = {addr_s2[`ADDR_RTT_HI], addr_s2[`ADDR_RTT_LO]};
        next_mod_cnt  = 4'(`MODE_UPDATE_WINDOW_CK);
        next_mod_busy = 1'b1;
      end else if (mod_busy) begin
        if (mod_cnt <= 4'h1) begin
          next_rtt_setting = rtt_pend;
          next_mod_busy    = 1'b0;
          next_mod_cnt     = 4'h0;
        end else begin
          next_mod_cnt = mod_cnt - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hist        <= 3'h0;
      term_on     <= 1'b0;
      rtt_pend    <= `RTT_RESET;
      rtt_setting <= `RTT_RESET;
      mod_cnt     <= 4'h0;
      mod_busy    <= 1'b0;
    end else begin
      hist        <= next_hist;
      term_on     <= next_term_on;
      rtt_pend    <= next_rtt_pend;
      rtt_setting <= next_rtt_setting;
      mod_cnt     <= next_mod_cnt;
      mod_busy    <= next_mod_busy;
    end
  end

  // Drive mode: outputs switch on and off one calibration delay after the command.
  always_comb begin
    next_drv          = drv;
    next_oit_cnt      = oit_cnt;
    next_level        = level;
    next_drive_active = drive_active;
    next_dq_out       = dq_out;
    next_dq_oe        = dq_oe;
    if (ck_rise) begin
      if (cmd_s2 == CMD_DRIVE_HIGH || cmd_s2 == CMD_DRIVE_LOW) begin
        next_drv     = DRV_ENTER;
        next_level   = (cmd_s2 == CMD_DRIVE_HIGH);
        next_oit_cnt = 4'(`CALIB_OUTPUT_DELAY_CK);
      end else if (cmd_s2 == CMD_CAL_EXIT && drv != DRV_OFF) begin
        next_drv     = DRV_EXIT;
        next_oit_cnt = 4'(`CALIB_OUTPUT_DELAY_CK);
      end else if (drv == DRV_ENTER || drv == DRV_EXIT) begin
        if (oit_cnt <= 4'h1) begin
          next_drv = (drv == DRV_ENTER) ? DRV_ON : DRV_OFF;
        end else begin
          next_oit_cnt = oit_cnt - 4'h1;
        end
      end
    end
    case (next_drv)
      DRV_ON: begin
        next_drive_active = 1'b1;
        next_dq_oe        = 1'b1;
        next_dq_out       = {8{next_level}};
      end
      DRV_OFF: begin
        next_drive_active = 1'b0;
        next_dq_oe        = 1'b0;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drv          <= DRV_OFF;
      oit_cnt      <= 4'h0;
      level        <= 1'b0;
      drive_active <= 1'b0;
      dq_out       <= 8'h00;
      dq_oe        <= 1'b0;
    end else begin
      drv          <= next_drv;
      oit_cnt      <= next_oit_cnt;
      level        <= next_level;
      drive_active <= next_drive_active;
      dq_out       <= next_dq_out;
      dq_oe        <= next_dq_oe;
    end
  end

  assign link.dq_d    = dq_out;
  assign link.dq_d_oe = dq_oe;

  // Adjust mode: wait the write latency, then take four beats of bit 0.
  always_comb begin
    next_adj            = adj;
    next_adj_cnt        = adj_cnt;
    next_beat           = beat;
    next_adjust_pattern = adjust_pattern;
    next_adjust_valid   = 1'b0;
    if (ck_rise) begin
      case (adj)
        ADJ_IDLE: begin
          if (cmd_s2 == CMD_ADJUST) begin
            next_adj_cnt = write_latency(additive_latency, cas_latency);
            next_adj     = ADJ_WAIT;
          end
        end
        ADJ_WAIT: begin
          if (adj_cnt <= 4'h1) begin
            next_adjust_pattern[0] = dq_s2[0];
            next_beat              = 2'h1;
            next_adj               = ADJ_DATA;
          end else begin
            next_adj_cnt = adj_cnt - 4'h1;
          end
        end
        ADJ_DATA: begin
          next_adjust_pattern[beat] = dq_s2[0];
          next_beat                 = beat + 2'h1;
          if (beat == 2'h3) begin
            next_adjust_valid = 1'b1;
            next_adj          = ADJ_IDLE;
          end
        end
        default: begin
          next_adj = ADJ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adj            <= ADJ_IDLE;
      adj_cnt        <= 4'h0;
      beat           <= 2'h0;
      adjust_pattern <= 4'h0;
      adjust_valid   <= 1'b0;
    end else begin
      adj            <= next_adj;
      adj_cnt        <= next_adj_cnt;
      beat           <= next_beat;
      adjust_pattern <= next_adjust_pattern;
      adjust_valid   <= next_adjust_valid;
    end
  end

endmodule : dram_cal_end

// ---- hw/ctrl_cal_end.sv ----
// Controller end: makes the link clock, sequences calibration and termination.
// Assumes user requests come from logic on clk; link data returns asynchronously.
`timescale 1ns/1ps
`include "cal_link_defs.svh"
module ctrl_cal_end
  import cal_link_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  cal_link.ctrl           link,
  input  wire logic       req_valid,
  input  wire op_e        req_op,
  input  wire logic [3:0] req_arg,
  input  wire logic [2:0] additive_latency,
  input  wire logic [2:0] cas_latency,
  input  wire logic       refresh_violation,
  output logic            req_ready,
  output logic            req_refused,
  output logic            data_stale,
  output logic [7:0]      dq_seen
);

  typedef enum logic [2:0] {C_IDLE, C_TOFF, C_EMR, C_MOD, C_ADJ_WAIT, C_ADJ_DATA} st_e;

  logic [2:0]  div, next_div;
  logic        fall_en;
  logic [7:0]  dq_s1;
  st_e         st, next_st;
  logic        pend, next_pend;
  op_e         op, next_op;
  logic [3:0]  arg, next_arg;
  logic [3:0]  cnt, next_cnt;
  logic [1:0]  beat, next_beat;
  logic        want_term, next_want_term;
  logic        ck, next_ck;
  cmd_e        cmd, next_cmd;
  logic [12:0] addr, next_addr;
  logic        term, next_term;
  logic [7:0]  dq_c, next_dq_c;
  logic        dq_c_oe, next_dq_c_oe;
  logic        next_req_ready, next_req_refused, next_data_stale;

  // Link clock divider; outputs change at the falling edge, mid-cycle.
  // Reset parks it one step before wrap so the first link pulse is full width.
  assign next_div = div + 3'h1;
  assign fall_en  = (div == 3'(`CK_HALF - 1));
  assign next_ck  = next_div < 3'(`CK_HALF);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div <= 3'(`CK_DIV - 1);
    end else begin
      div <= next_div;
    end
  end

  // Returned data passes two flops before use.
  always_ff @(posedge clk) begin
    dq_s1   <= link.dq;
    dq_seen <= dq_s1;
  end

  // Request intake and command sequencer.
  always_comb begin
    next_st          = st;
    next_pend        = pend;
    next_op          = op;
    next_arg         = arg;
    next_cnt         = cnt;
    next_beat        = beat;
    next_want_term   = want_term;
    next_cmd         = cmd;
    next_addr        = addr;
    next_term        = term;
    next_dq_c        = dq_c;
    next_dq_c_oe     = dq_c_oe;
    next_req_refused = 1'b0;
    next_data_stale  = data_stale;
    if (req_valid && req_ready) begin
      next_pend = 1'b1;
      next_op   = req_op;
      next_arg  = req_arg;
    end
    if (fall_en) begin
      next_cmd = CMD_NOP;
      case (st)
        C_IDLE: begin
          if (pend) begin
            next_pend = 1'b0;
            case (op)
              OP_DRIVE_HIGH, OP_DRIVE_LOW: begin
                if (data_stale) begin
                  next_req_refused = 1'b1;
                end else begin
                  next_cmd = (op == OP_DRIVE_HIGH) ? CMD_DRIVE_HIGH : CMD_DRIVE_LOW;
                end
              end
              OP_CAL_EXIT: next_cmd = CMD_CAL_EXIT;
              OP_ADJUST: begin
                next_cmd = CMD_ADJUST;
                next_cnt = write_latency(additive_latency, cas_latency);
                next_st  = C_ADJ_WAIT;
              end
              OP_SET_RTT: begin
                next_term = 1'b0;
                next_cnt  = 4'(`TERM_OFF_DELAY_CK);
                next_st   = C_TOFF;
              end
              OP_TERM_ON: begin
                next_want_term = 1'b1;
                next_term      = 1'b1;
              end
              default: begin
                next_want_term = 1'b0;
                next_term      = 1'b0;
              end
            endcase
          end
        end
        C_TOFF: begin
          if (cnt == 4'h0) begin
            next_cmd  = CMD_EXT_REG_ONE_WR;
            next_addr = 13'h0000;
            next_addr[`ADDR_RTT_HI] = arg[1];
            next_addr[`ADDR_RTT_LO] = arg[0];
            next_cnt  = 4'(`MODE_UPDATE_WINDOW_CK);
            next_st   = C_MOD;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
        C_MOD: begin
          if (cnt == 4'h0) begin
            next_term = want_term;
            next_st   = C_IDLE;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
        C_ADJ_WAIT: begin
          if (cnt <= 4'h1) begin
            next_dq_c    = {7'h00, arg[0]};
            next_dq_c_oe = 1'b1;
            next_beat    = 2'h1;
            next_st      = C_ADJ_DATA;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
        C_ADJ_DATA: begin
          if (beat == 2'h0) begin
            next_dq_c_oe    = 1'b0;
            next_data_stale = 1'b0;
            next_st         = C_IDLE;
          end else begin
            next_dq_c = {7'h00, arg[beat]};
            next_beat = beat + 2'h1;
          end
        end
        default: next_st = C_IDLE;
      endcase
    end
    // A violation in the same cycle as a rewrite wins.
    if (refresh_violation) begin
      next_data_stale = 1'b1;
    end
    next_req_ready = (next_st == C_IDLE) && !next_pend;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st          <= C_IDLE;
      pend        <= 1'b0;
      op          <= OP_CAL_EXIT;
      arg         <= 4'h0;
      cnt         <= 4'h0;
      beat        <= 2'h0;
      want_term   <= 1'b0;
      ck          <= 1'b0;
      cmd         <= CMD_NOP;
      addr        <= 13'h0000;
      term        <= 1'b0;
      dq_c        <= 8'h00;
      dq_c_oe     <= 1'b0;
      req_ready   <= 1'b0;
      req_refused <= 1'b0;
      data_stale  <= 1'b0;
    end else begin
      st          <= next_st;
      pend        <= next_pend;
      op          <= next_op;
      arg         <= next_arg;
      cnt         <= next_cnt;
      beat        <= next_beat;
      want_term   <= next_want_term;
      ck          <= next_ck;
      cmd         <= next_cmd;
      addr        <= next_addr;
      term        <= next_term;
      dq_c        <= next_dq_c;
      dq_c_oe     <= next_dq_c_oe;
      req_ready   <= next_req_ready;
      req_refused <= next_req_refused;
      data_stale  <= next_data_stale;
    end
  end

  assign link.ck       = ck;
  assign link.cmd      = cmd;
  assign link.addr     = addr;
  assign link.term_ctl = term;
  assign link.dq_c     = dq_c;
  assign link.dq_c_oe  = dq_c_oe;

endmodule : ctrl_cal_end

// ---- tb/cal_link_props.sv ----
// Checker for the signals of the calibration link between the two ends.
// Assumes the bench instantiates it beside the link, with a static write latency.
`timescale 1ns/1ps
module cal_link_props
  import cal_link_pkg::*;
#(
  parameter int WRITE_LAT_CK = 4
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ck,
  input wire cmd_e        cmd,
  input wire logic [12:0] addr,
  input wire logic        term_ctl,
  input wire logic [7:0]  dq_c,
  input wire logic        dq_c_oe,
  input wire logic [7:0]  dq_d,
  input wire logic        dq_d_oe,
  input wire logic [7:0]  dq
);
  localparam int ADJ_LAG = WRITE_LAT_CK * 8 - 4;

  logic [7:0] oe_run;
  logic [7:0] next_oe_run;
  logic [7:0] low_run;
  logic [7:0] next_low_run;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Counts how long the controller drives adjust beats and how long termination is low.
  always_comb begin
    next_oe_run  = dq_c_oe ? oe_run + 8'h01 : 8'h00;
    next_low_run = term_ctl ? 8'h00 : ((low_run == 8'hff) ? low_run : low_run + 8'h01);
  end

  // Registers the run counters.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oe_run  <= 8'h00;
      low_run <= 8'h00;
    end else begin
      oe_run  <= next_oe_run;
      low_run <= next_low_run;
    end
  end

  sequence s_cmd_is(cmd_e c);
    $changed(cmd) && (cmd == c);
  endsequence

  sequence s_ck_cycle;
    ck [*4] ##1 !ck [*4] ##1 ck;
  endsequence

  sequence s_term_low_16;
    !term_ctl [*8] ##1 !term_ctl [*8];
  endsequence

  a_ck_link_shape: assert property ($rose(ck) |-> s_ck_cycle)
    else $error("link clock is not four high and four low");
  a_cmd_at_fall: assert property ($changed(cmd) |-> $fell(ck))
    else $error("command changed away from a link clock fall");
  a_cmd_held_cycle: assert property ($changed(cmd) && cmd != CMD_NOP |=> $stable(cmd) [*7])
    else $error("command not held for one link clock cycle");
  a_drive_high_on: assert property (s_cmd_is(CMD_DRIVE_HIGH) |->
    ##[8:28] (dq_d_oe && dq_d == 8'hff))
    else $error("drive high did not switch all outputs on");
  a_drive_low_on: assert property (s_cmd_is(CMD_DRIVE_LOW) |->
    ##[8:28] (dq_d_oe && dq_d == 8'h00))
    else $error("drive low did not switch all outputs on");
  a_cal_exit_off: assert property (s_cmd_is(CMD_CAL_EXIT) and dq_d_oe |->
    ##[8:28] !dq_d_oe)
    else $error("calibration exit did not release the drivers");
  a_drive_pattern_only: assert property (dq_d_oe |->
    (dq_d == 8'hff || dq_d == 8'h00))
    else $error("memory drives something other than a drive pattern");
  a_no_bus_fight: assert property (!(dq_d_oe && dq_c_oe) && (!dq_d_oe || dq == dq_d))
    else $error("both ends drive the data bus");
  a_adjust_latency: assert property ($rose(dq_c_oe) |->
    $past(cmd, ADJ_LAG) == CMD_ADJUST)
    else $error("adjust data not placed at the write latency");
  a_adjust_four_beats: assert property ($fell(dq_c_oe) |-> oe_run == 8'h20)
    else $error("adjust burst is not four link cycles long");
  a_adjust_bit_zero: assert property (dq_c_oe |-> dq_c[7:1] == 7'h00)
    else $error("adjust beat drives a data line other than bit zero");
  a_term_off_first: assert property (s_cmd_is(CMD_EXT_REG_ONE_WR) |->
    low_run >= 8'h18)
    else $error("register write before termination turn-off delay");
  a_term_low_window: assert property (s_cmd_is(CMD_EXT_REG_ONE_WR) |->
    s_term_low_16)
    else $error("termination raised inside the mode update window");
  a_reg_write_field: assert property (s_cmd_is(CMD_EXT_REG_ONE_WR) |->
    (addr & 13'h1fbb) == 13'h0000)
    else $error("register write sets address bits outside the termination field");
endmodule : cal_link_props

// ---- tb/ocd_odt_update_sequencing_tb.sv ----
// Testbench joining the controller end and the memory end over one link.
// Assumes the design files and the link checker are compiled before it.
`timescale 1ns/1ps
`include "cal_link_defs.svh"
module ocd_odt_update_sequencing_tb
  import cal_link_pkg::*;
;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       req_valid = 1'b0;
  op_e        req_op = OP_TERM_OFF;
  logic [3:0] req_arg = 4'h0;
  logic [2:0] additive_latency = 3'h2;
  logic [2:0] cas_latency = 3'h3;
  logic       refresh_violation = 1'b0;
  logic       req_ready, req_refused, data_stale, term_on, adjust_valid, drive_active;
  logic [7:0] dq_seen;
  logic [1:0] rtt_setting;
  logic [3:0] adjust_pattern;
  logic [3:0] got_pat = 4'h0;
  logic [1:0] emr_bits = 2'h0;
  int         n_refused = 0;
  logic       ck_prev = 1'b0;
  int         n_fail = 0;
  int         num_checks = 0;
  int         n_adj = 0;

  // Makes the 250 MHz system clock.
  always #2 clk = ~clk;

  cal_link link ();

  ctrl_cal_end i_ctrl_cal_end (.clk(clk), .reset_n(reset_n), .link(link),
    .req_valid(req_valid), .req_op(req_op), .req_arg(req_arg),
    .additive_latency(additive_latency), .cas_latency(cas_latency),
    .refresh_violation(refresh_violation), .req_ready(req_ready),
    .req_refused(req_refused), .data_stale(data_stale), .dq_seen(dq_seen));

  dram_cal_end i_dram_cal_end (.clk(clk), .reset_n(reset_n), .link(link),
    .additive_latency(additive_latency), .cas_latency(cas_latency), .term_on(term_on),
    .rtt_setting(rtt_setting), .adjust_pattern(adjust_pattern),
    .adjust_valid(adjust_valid), .drive_active(drive_active));

  cal_link_props #(.WRITE_LAT_CK(4)) i_cal_link_props (.clk(clk), .reset_n(reset_n),
    .ck(link.ck), .cmd(link.cmd), .addr(link.addr), .term_ctl(link.term_ctl),
    .dq_c(link.dq_c), .dq_c_oe(link.dq_c_oe), .dq_d(link.dq_d), .dq_d_oe(link.dq_d_oe),
    .dq(link.dq));

  // Captures one-cycle pulses and register write bits so that tasks can judge them later.
  always @(posedge clk) begin
    ck_prev <= link.ck;
    if (adjust_valid === 1'b1) begin
      got_pat <= adjust_pattern;
      n_adj   <= n_adj + 1;
    end
    if (req_refused === 1'b1) begin
      n_refused <= n_refused + 1;
    end
    if (link.cmd === CMD_EXT_REG_ONE_WR) begin
      emr_bits <= {link.addr[6], link.addr[2]};
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks

  // Waits for the given number of link clock rises seen on the system clock.
  task automatic ck_rises(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clk);
      if (link.ck === 1'b1 && ck_prev === 1'b0) k++;
    end
  endtask : ck_rises

  // Waits for a bounded time until the controller is ready again.
  task automatic finish_req;
    int n;
    for (n = 0; n < 3000 && req_ready !== 1'b1; n++) @(posedge clk);
    chk_bit(req_ready, 1'b1);
  endtask : finish_req

  task automatic start_req(input op_e op, input logic [3:0] arg);
    finish_req;
    req_valid <= 1'b1;
    req_op    <= op;
    req_arg   <= arg;
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
  endtask : start_req

  task automatic do_req(input op_e op, input logic [3:0] arg);
    start_req(op, arg);
    finish_req;
  endtask : do_req

  task automatic t_idle;
    chk_val({6'h00, rtt_setting}, {6'h00, `RTT_RESET});
    chk_bit(link.dq_d_oe, 1'b0);
    chk_bit(drive_active, 1'b0);
  endtask : t_idle

  task automatic t_drive;
    for (int i = 0; i < 2; i++) begin
      do_req(i ? OP_DRIVE_LOW : OP_DRIVE_HIGH, 4'h0);
      ticks(40);
      chk_bit(drive_active, 1'b1);
      chk_bit(link.dq_d_oe, 1'b1);
      chk_val(link.dq, i ? 8'h00 : 8'hff);
      chk_val(dq_seen, i ? 8'h00 : 8'hff);
      do_req(OP_CAL_EXIT, 4'h0);
      ticks(40);
      chk_bit(link.dq_d_oe, 1'b0);
      chk_bit(drive_active, 1'b0);
    end
  endtask : t_drive

  task automatic t_term;
    int n;
    for (int i = 0; i < 2; i++) begin
      start_req(i ? OP_TERM_OFF : OP_TERM_ON, 4'h0);
      for (n = 0; n < 100 && link.term_ctl !== (i == 0); n++) @(posedge clk);
      chk_bit(link.term_ctl, i == 0);
      ck_rises(i ? 4 : 3);
      chk_bit(term_on, i == 1);
      ticks(6);
      chk_bit(term_on, i == 0);
      finish_req;
    end
    do_req(OP_TERM_ON, 4'h0);
  endtask : t_term

  task automatic t_rtt;
    logic [1:0] vals [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      do_req(OP_SET_RTT, {2'b00, vals[i]});
      chk_val({6'h00, emr_bits}, {6'h00, vals[i]});
      chk_val({6'h00, rtt_setting}, {6'h00, vals[i]});
      ticks(40);
      chk_bit(term_on, 1'b1);
    end
  endtask : t_rtt

  task automatic t_adjust;
    int n0;
    int r0;
    refresh_violation <= 1'b1;
    @(posedge clk);
    refresh_violation <= 1'b0;
    ticks(2);
    chk_bit(data_stale, 1'b1);
    r0 = n_refused;
    do_req(OP_DRIVE_HIGH, 4'h0);
    ticks(12);
    chk_bit(n_refused == r0 + 1, 1'b1);
    chk_bit(drive_active, 1'b0);
    n0 = n_adj;
    do_req(OP_ADJUST, 4'hd);
    ticks(60);
    chk_bit(n_adj == n0 + 1, 1'b1);
    chk_val({4'h0, got_pat}, 8'h0d);
    chk_bit(data_stale, 1'b0);
    r0 = n_refused;
    do_req(OP_DRIVE_LOW, 4'h0);
    ticks(40);
    chk_bit(drive_active, 1'b1);
    chk_bit(n_refused == r0, 1'b1);
    do_req(OP_CAL_EXIT, 4'h0);
    ticks(40);
  endtask : t_adjust

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Holds reset for ten cycles, then runs every scenario in turn.
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    ticks(3);
    t_idle;
    t_drive;
    t_term;
    t_rtt;
    t_adjust;
    end_of_test;
  end

  // Cuts a hang short long after the scenarios should have finished.
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end
endmodule : ocd_odt_update_sequencing_tb
